// *** src/cpu_core.sv ***
// instruction sequencer, alu and interrupt logic of the controller cpu
`timescale 1ns/1ps
module cpu_core
   import cpu_core_pkg::*;
(
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   // memory bus
   output logic [AW-1:0]      mem_addr_o,
   output logic               mem_rd_o,
   output logic               mem_wr_o,
   output logic [7:0]         mem_wdata_o,
   input  wire logic [7:0]    mem_rdata_i,
   // interrupt sources
   input  wire logic          ext_irq_n_i,
   input  wire logic [1:0]    int_mode_i,
   input  wire logic          timer_zero_i,
   // status
   output logic               irq_mask_o,
   output logic               tmr_flag_o,
   output logic               tmr_mask_o
);
   state_t state_reg, state_next;
   logic [7:0] a_reg, a_next, x_reg, x_next, sp_reg, sp_next, op_reg, op_next;
   logic [7:0] b1_reg, b1_next, wdata_reg, wdata_next;
   logic [AW-1:0] pc_reg, pc_next, ea_reg, ea_next, addr_reg, addr_next, mem_ea;
   logic [4:0] ccr_reg, ccr_next;
   logic [2:0] cnt_reg, cnt_next;
   logic call_reg, call_next, rd_reg, rd_next, wr_reg, wr_next, rdt_reg, rdt_next;
   logic ext_reg, ext_next, pin_reg, tflag_reg, tflag_next, tmask_reg, tmask_next;
   logic [7:0] din, opc, opnd, alu_r, rmw_m, rmw_r, push_byte;
   logic alu_c, alu_h, rmw_c, irq_take, go_mem, do_alu, do_rmw, tcr_wr, ext_set;
   logic [3:0] lo;
   logic [8:0] s9;

   // condition of a relative branch from its opcode
   function automatic logic br_cond(input logic [3:0] o, input logic [4:0] f,
                                    input logic pin);
      logic t;
      unique case (o[3:1])
         3'h0: t = 1'b1;
         3'h1: t = ~(f[CC_C] | f[CC_Z]);
         3'h2: t = ~f[CC_C];
         3'h3: t = ~f[CC_Z];
         3'h4: t = ~f[CC_H];
         3'h5: t = ~f[CC_N];
         3'h6: t = ~f[CC_I];
         3'h7: t = ~pin;
      endcase
      return t ^ o[0];
   endfunction

   function automatic logic [AW-1:0] rel(input logic [7:0] b);
      return {{(AW-8){b[7]}}, b};
   endfunction

   // internal timer control byte overrides the bus on reads of its address
   assign din = rdt_reg ? {tflag_reg, tmask_reg, 6'h00} : mem_rdata_i;
   assign opc = (state_reg == S_DECODE) ? din : op_reg;
   assign lo  = opc[3:0];
   assign tcr_wr = wr_reg && addr_reg == TCR_ADDR;
   assign irq_take = ~ccr_reg[CC_I] & (ext_reg | (tflag_reg & ~tmask_reg));

   // alu for register/memory ops
   always_comb
   begin
      opnd = (lo == L_CPX || lo == L_STX) ? x_reg : a_reg;
      unique case (lo)
         L_SUB, L_CMP, L_CPX: s9 = {1'b0, opnd} - {1'b0, din};
         L_SBC: s9 = {1'b0, opnd} - {1'b0, din} - {8'h00, ccr_reg[CC_C]};
         L_ADD: s9 = {1'b0, opnd} + {1'b0, din};
         L_ADC: s9 = {1'b0, opnd} + {1'b0, din} + {8'h00, ccr_reg[CC_C]};
         L_AND, L_BIT: s9 = {1'b0, opnd & din};
         L_EOR: s9 = {1'b0, opnd ^ din};
         L_ORA: s9 = {1'b0, opnd | din};
         L_LDA, L_LDX: s9 = {1'b0, din};
         default: s9 = {1'b0, opnd};
      endcase
      alu_r = s9[7:0];
      alu_c = s9[8];
      alu_h = opnd[4] ^ din[4] ^ alu_r[4];
      // modify operations; left shifts share one path
      rmw_m = (state_reg == S_MEMRD) ? din : (opc[4] ? x_reg : a_reg);
      rmw_c = ccr_reg[CC_C];
      unique case (lo)
         R_NEG: begin rmw_r = 8'h00 - rmw_m; rmw_c = rmw_m != 8'h00; end
         R_COM: begin rmw_r = ~rmw_m; rmw_c = 1'b1; end
         R_LSR: begin rmw_r = {1'b0, rmw_m[7:1]}; rmw_c = rmw_m[0]; end
         R_ROR: begin rmw_r = {ccr_reg[CC_C], rmw_m[7:1]}; rmw_c = rmw_m[0]; end
         R_ASR: begin rmw_r = {rmw_m[7], rmw_m[7:1]}; rmw_c = rmw_m[0]; end
         R_LSL: begin rmw_r = {rmw_m[6:0], 1'b0}; rmw_c = rmw_m[7]; end
         R_ROL: begin rmw_r = {rmw_m[6:0], ccr_reg[CC_C]}; rmw_c = rmw_m[7]; end
         R_DEC: rmw_r = rmw_m - 8'h01;
         R_INC: rmw_r = rmw_m + 8'h01;
         R_CLR: rmw_r = 8'h00;
         default: rmw_r = rmw_m;
      endcase
      unique case (cnt_reg)
         3'h0: push_byte = pc_reg[7:0];
         3'h1: push_byte = {{(16-AW){1'b0}}, pc_reg[AW-1:8]};
         3'h2: push_byte = x_reg;
         3'h3: push_byte = a_reg;
         default: push_byte = {CC_PAD, ccr_reg};
      endcase
   end

   // request latches; a new event wins over a clear in the same cycle
   always_comb
   begin
      unique case (int_mode_i)
         INT_FALL: ext_set = pin_reg & ~ext_irq_n_i;
         INT_ZERO: ext_set = pin_reg ^ ext_irq_n_i;
         default: ext_set = ~ext_irq_n_i;
      endcase
      // held until the trap is taken
      ext_next = ext_set | (ext_reg & ~(state_reg == S_FETCH && irq_take));
      // only a write of zero to bit 7 clears it
      tflag_next = timer_zero_i | (tflag_reg & ~(tcr_wr & ~wdata_reg[TCR_FLAG]));
      tmask_next = tcr_wr ? wdata_reg[TCR_MASK] : tmask_reg;
   end

   // sequencer: each state drives the bus for the next cycle
   always_comb
   begin
      state_next = state_reg;
      a_next = a_reg; x_next = x_reg; sp_next = sp_reg; pc_next = pc_reg;
      op_next = op_reg; b1_next = b1_reg; ea_next = ea_reg; ccr_next = ccr_reg;
      cnt_next = cnt_reg; call_next = call_reg; wdata_next = wdata_reg;
      addr_next = addr_reg; rd_next = 1'b0; wr_next = 1'b0;
      go_mem = 1'b0; mem_ea = ea_reg; do_alu = 1'b0; do_rmw = 1'b0;
      unique case (state_reg)
         S_RST:
         begin
            ea_next = VEC_RESET; addr_next = VEC_RESET; rd_next = 1'b1;
            state_next = S_VECH;
         end
         S_VECH:
         begin
            pc_next[AW-1:8] = din[AW-9:0];
            addr_next = {ea_reg[AW-1:1], 1'b1}; rd_next = 1'b1;
            state_next = S_VECL;
         end
         S_VECL:
         begin
            pc_next[7:0] = din;
            state_next = S_FETCH;
         end
         S_FETCH:
            if (irq_take)
            begin
               ea_next = ext_reg ? VEC_EXT : VEC_TIMER;
               cnt_next = 3'h0; call_next = 1'b0; state_next = S_PUSH;
            end
            else
            begin
               addr_next = pc_reg; rd_next = 1'b1;
               pc_next = pc_reg + 1'b1; state_next = S_DECODE;
            end
         S_DECODE:
         begin
            op_next = din;
            state_next = S_OPB1;
            addr_next = pc_reg; rd_next = 1'b1; pc_next = pc_reg + 1'b1;
            unique case (din[7:4])
               HI_RMW_A, HI_RMW_X:
               begin
                  do_rmw = 1'b1; rd_next = 1'b0; pc_next = pc_reg;
                  state_next = S_FETCH;
                  if (lo != R_TST && din[4]) x_next = rmw_r;
                  else if (lo != R_TST) a_next = rmw_r;
               end
               HI_RMW_IX, HI_IX:
               begin
                  rd_next = 1'b0; pc_next = pc_reg;
                  go_mem = 1'b1; mem_ea = {ZPAD, x_reg};
               end
               HI_CTL0, HI_CTL1:
               begin
                  rd_next = 1'b0; pc_next = pc_reg; state_next = S_FETCH;
                  // inherent control set; unknown codes do nothing
                  unique case (din)
                     OP_RTI: begin cnt_next = 3'h0; state_next = S_PULL; end
                     OP_RTS: begin cnt_next = RTS_FIRST; state_next = S_PULL; end
                     OP_SWI:
                     begin
                        ea_next = VEC_TRAP; cnt_next = 3'h0; call_next = 1'b0;
                        state_next = S_PUSH;
                     end
                     OP_TAX: x_next = a_reg;
                     OP_TXA: a_next = x_reg;
                     OP_CLC: ccr_next[CC_C] = 1'b0;
                     OP_SEC: ccr_next[CC_C] = 1'b1;
                     OP_CLI: ccr_next[CC_I] = 1'b0;
                     OP_SEI: ccr_next[CC_I] = 1'b1;
                     OP_RSP: sp_next = SP_RESET;
                     default: ;
                  endcase
               end
               HI_IMM:
                  // immediate store or jump runs as a no-op
                  if (din != OP_BSR && (lo == L_STA || lo == L_STX || lo == L_JMP))
                  begin
                     rd_next = 1'b0; pc_next = pc_reg; state_next = S_FETCH;
                  end
               default: ;
            endcase
         end
         S_OPB1:
         begin
            b1_next = din;
            state_next = S_FETCH;
            unique case (op_reg[7:4])
               HI_BRA:
                  if (br_cond(op_reg[3:0], ccr_reg, ext_irq_n_i)) pc_next = pc_reg + rel(din);
               HI_IMM:
                  if (op_reg == OP_BSR)
                  begin
                     ea_next = pc_reg + rel(din); cnt_next = 3'h0; call_next = 1'b1;
                     state_next = S_PUSH;
                  end
                  else do_alu = 1'b1;
               HI_BTB, HI_BSC, HI_RMW_DIR, HI_DIR:
               begin
                  go_mem = 1'b1; mem_ea = {ZPAD, din};
               end
               HI_RMW_IX1, HI_IX1:
               begin
                  go_mem = 1'b1; mem_ea = {ZPAD, din} + {ZPAD, x_reg};
               end
               default:
               begin
                  addr_next = pc_reg; rd_next = 1'b1; pc_next = pc_reg + 1'b1;
                  state_next = S_OPB2;
               end
            endcase
         end
         S_OPB2:
         begin
            go_mem = 1'b1;
            mem_ea = {b1_reg[AW-9:0], din} + ((op_reg[7:4] == HI_IX2) ? {ZPAD, x_reg} : '0);
         end
         S_MEMRD:
         begin
            state_next = S_FETCH;
            unique case (op_reg[7:4])
               HI_BTB:
               begin
                  ccr_next[CC_C] = din[op_reg[3:1]];
                  addr_next = pc_reg; rd_next = 1'b1; pc_next = pc_reg + 1'b1;
                  state_next = S_BRREL;
               end
               HI_BSC:
               begin
                  wdata_next = din;
                  wdata_next[op_reg[3:1]] = ~op_reg[0];
                  addr_next = ea_reg; wr_next = 1'b1;
               end
               HI_RMW_DIR, HI_RMW_IX1, HI_RMW_IX:
               begin
                  // write back to the same location
                  do_rmw = 1'b1; addr_next = ea_reg;
                  wr_next = lo != R_TST; wdata_next = rmw_r;
               end
               default: do_alu = 1'b1;
            endcase
         end
         S_BRREL:
         begin
            // set or clear sense from the opcode
            if (ccr_reg[CC_C] ^ op_reg[0]) pc_next = pc_reg + rel(din);
            state_next = S_FETCH;
         end
         S_PUSH:
         begin
            // mask further traps, then read vector high byte
            // the vector read needs its own cycle, the last push still holds the bus
            if (!call_reg && cnt_reg == PUSH_LAST + 3'h1)
            begin
               ccr_next[CC_I] = 1'b1; addr_next = ea_reg; rd_next = 1'b1;
               state_next = S_VECH;
            end
            else
            begin
               addr_next = {ZPAD, sp_reg}; wr_next = 1'b1; wdata_next = push_byte;
               sp_next = sp_reg - 8'h01; cnt_next = cnt_reg + 3'h1;
               if (call_reg && cnt_reg == CALL_LAST)
               begin
                  pc_next = ea_reg; state_next = S_FETCH;
               end
            end
         end
         S_PULL:
         begin
            sp_next = sp_reg + 8'h01;
            addr_next = {ZPAD, sp_next}; rd_next = 1'b1; state_next = S_PULLC;
         end
         S_PULLC:
         begin
            unique case (cnt_reg)
               3'h0: ccr_next = din[4:0];
               3'h1: a_next = din;
               3'h2: x_next = din;
               3'h3: pc_next[AW-1:8] = din[AW-9:0];
               default: pc_next[7:0] = din;
            endcase
            cnt_next = cnt_reg + 3'h1;
            state_next = (cnt_reg == PUSH_LAST) ? S_FETCH : S_PULL;
         end
         default: state_next = S_RST;
      endcase
      // memory operand dispatch for every memory mode
      if (go_mem)
      begin
         ea_next = mem_ea; addr_next = mem_ea; rd_next = 1'b1; state_next = S_MEMRD;
         if (opc[7])
            unique case (lo)
               L_STA, L_STX:
               begin
                  rd_next = 1'b0; wr_next = 1'b1; wdata_next = alu_r; do_alu = 1'b1;
                  state_next = S_FETCH;
               end
               L_JMP: begin rd_next = 1'b0; pc_next = mem_ea; state_next = S_FETCH; end
               L_JSR:
               begin
                  rd_next = 1'b0; cnt_next = 3'h0; call_next = 1'b1; state_next = S_PUSH;
               end
               default: ;
            endcase
      end
      if (do_alu)
      begin
         ccr_next[CC_N] = alu_r[7];
         ccr_next[CC_Z] = alu_r == 8'h00;
         if (lo inside {L_SUB, L_CMP, L_SBC, L_CPX, L_ADC, L_ADD}) ccr_next[CC_C] = alu_c;
         if (lo inside {L_ADC, L_ADD}) ccr_next[CC_H] = alu_h;
         if (lo inside {L_SUB, L_SBC, L_AND, L_LDA, L_EOR, L_ADC, L_ORA, L_ADD})
            a_next = alu_r;
         if (lo == L_LDX) x_next = alu_r;
      end
      if (do_rmw)
      begin
         ccr_next[CC_N] = rmw_r[7]; ccr_next[CC_Z] = rmw_r == 8'h00; ccr_next[CC_C] = rmw_c;
      end
      rdt_next = rd_next && addr_next == TCR_ADDR;
   end

   // state registers; reset leaves both masks set
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= S_RST; a_reg <= 8'h00; x_reg <= 8'h00; sp_reg <= SP_RESET;
         pc_reg <= '0; op_reg <= 8'h00; b1_reg <= 8'h00; ea_reg <= '0;
         ccr_reg <= CC_RESET; cnt_reg <= 3'h0; call_reg <= 1'b0;
         wdata_reg <= 8'h00; addr_reg <= '0; rd_reg <= 1'b0; wr_reg <= 1'b0;
         rdt_reg <= 1'b0; ext_reg <= 1'b0; pin_reg <= 1'b1;
         tflag_reg <= 1'b0; tmask_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next; a_reg <= a_next; x_reg <= x_next; sp_reg <= sp_next;
         pc_reg <= pc_next; op_reg <= op_next; b1_reg <= b1_next; ea_reg <= ea_next;
         ccr_reg <= ccr_next; cnt_reg <= cnt_next; call_reg <= call_next;
         wdata_reg <= wdata_next; addr_reg <= addr_next; rd_reg <= rd_next;
         wr_reg <= wr_next; rdt_reg <= rdt_next; ext_reg <= ext_next;
         pin_reg <= ext_irq_n_i; tflag_reg <= tflag_next; tmask_reg <= tmask_next;
      end
   end

   // outputs straight from flip-flops
   assign mem_addr_o = addr_reg;
   assign mem_rd_o = rd_reg;
   assign mem_wr_o = wr_reg;
   assign mem_wdata_o = wdata_reg;
   assign irq_mask_o = ccr_reg[CC_I];
   assign tmr_flag_o = tflag_reg;
   assign tmr_mask_o = tmask_reg;

   // checks on the sequencer
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_reset_vector: assert property ((state_reg == S_RST) |=> (state_reg == S_VECH
      && mem_rd_o && mem_addr_o == VEC_RESET && ccr_reg[CC_I] && tmask_reg))
      else $error("reset vector fetch wrong");
   a_trap_mask: assert property ((state_reg == S_PUSH && !call_reg
      && cnt_reg == PUSH_LAST + 3'h1)
      |=> (ccr_reg[CC_I] && state_reg == S_VECH && mem_rd_o && mem_addr_o == ea_reg))
      else $error("mask not set before vector");
   a_push_order: assert property ((state_reg == S_PUSH && !call_reg && cnt_reg == 3'h0)
      |=> (mem_wr_o && mem_wdata_o == $past(pc_reg[7:0])) ##3 (mem_wdata_o == $past(a_reg, 4)))
      else $error("stacking order wrong");
   a_stack_dec: assert property ((state_reg == S_PUSH && cnt_reg <= PUSH_LAST)
      |=> (sp_reg == $past(sp_reg) - 8'h01))
      else $error("stack pointer not decremented");
   a_masked_hold: assert property ((state_reg == S_FETCH && ccr_reg[CC_I]) |=> (state_reg == S_DECODE))
      else $error("trap taken while masked");
   a_ext_prio: assert property ((state_reg == S_FETCH && irq_take && ext_reg) |=> (ea_reg == VEC_EXT))
      else $error("timer beat external");
   a_tmr_sticky: assert property ((tflag_reg && !tcr_wr) |=> tflag_reg)
      else $error("timer flag lost");
   a_ext_latch: assert property ((ext_reg && !(state_reg == S_FETCH && irq_take)) |=> ext_reg)
      else $error("external request lost");
   a_swi_any: assert property ((state_reg == S_DECODE && opc == OP_SWI)
      |=> (state_reg == S_PUSH && ea_reg == VEC_TRAP)) else $error("soft trap not taken");
endmodule

// *** shared/cpu_core_pkg.sv ***
// constants, opcode classes and states for the controller cpu core
package cpu_core_pkg;
   // address and stack geometry
   localparam int             AW        = 13;
   localparam logic [4:0]     ZPAD      = 5'h00;
   localparam logic [7:0]     SP_RESET  = 8'h7F;
   localparam logic [AW-1:0]  TCR_ADDR  = 13'h0009;
   // two-byte vectors in the top page
   localparam logic [AW-1:0]  VEC_TIMER = 13'h1FF8;
   localparam logic [AW-1:0]  VEC_EXT   = 13'h1FFA;
   localparam logic [AW-1:0]  VEC_TRAP  = 13'h1FFC;
   localparam logic [AW-1:0]  VEC_RESET = 13'h1FFE;
   // condition flag bits and timer control bits
   localparam int             CC_C = 0, CC_Z = 1, CC_N = 2, CC_I = 3, CC_H = 4;
   localparam logic [4:0]     CC_RESET  = 5'h08;
   localparam logic [2:0]     CC_PAD    = 3'h7;
   localparam int             TCR_MASK = 6, TCR_FLAG = 7;
   // external interrupt recognition modes
   localparam logic [1:0]     INT_FALL  = 2'h0, INT_ZERO = 2'h1;
   // push and pull byte counts
   localparam logic [2:0]     PUSH_LAST = 3'h4, CALL_LAST = 3'h1, RTS_FIRST = 3'h3;
   // opcode classes (high nibble)
   localparam logic [3:0]     HI_BTB = 4'h0, HI_BSC = 4'h1, HI_BRA = 4'h2, HI_RMW_DIR = 4'h3;
   localparam logic [3:0]     HI_RMW_A = 4'h4, HI_RMW_X = 4'h5, HI_RMW_IX1 = 4'h6;
   localparam logic [3:0]     HI_RMW_IX = 4'h7, HI_CTL0 = 4'h8, HI_CTL1 = 4'h9;
   localparam logic [3:0]     HI_IMM = 4'hA, HI_DIR = 4'hB, HI_EXT = 4'hC, HI_IX2 = 4'hD;
   localparam logic [3:0]     HI_IX1 = 4'hE, HI_IX = 4'hF;
   // control opcodes
   localparam logic [7:0]     OP_RTI = 8'h80, OP_RTS = 8'h81, OP_SWI = 8'h83, OP_TAX = 8'h97;
   localparam logic [7:0]     OP_CLC = 8'h98, OP_SEC = 8'h99, OP_CLI = 8'h9A, OP_SEI = 8'h9B;
   localparam logic [7:0]     OP_RSP = 8'h9C, OP_TXA = 8'h9F, OP_BSR = 8'hAD;
   // register/memory operations (low nibble)
   localparam logic [3:0]     L_SUB = 4'h0, L_CMP = 4'h1, L_SBC = 4'h2, L_CPX = 4'h3;
   localparam logic [3:0]     L_AND = 4'h4, L_BIT = 4'h5, L_LDA = 4'h6, L_STA = 4'h7;
   localparam logic [3:0]     L_EOR = 4'h8, L_ADC = 4'h9, L_ORA = 4'hA, L_ADD = 4'hB;
   localparam logic [3:0]     L_JMP = 4'hC, L_JSR = 4'hD, L_LDX = 4'hE, L_STX = 4'hF;
   // read-modify-write operations (low nibble)
   localparam logic [3:0]     R_NEG = 4'h0, R_COM = 4'h3, R_LSR = 4'h4, R_ROR = 4'h6;
   localparam logic [3:0]     R_ASR = 4'h7, R_LSL = 4'h8, R_ROL = 4'h9, R_DEC = 4'hA;
   localparam logic [3:0]     R_INC = 4'hC, R_TST = 4'hD, R_CLR = 4'hF;
   // sequencer states
   typedef enum logic [3:0] {
      S_RST, S_VECH, S_VECL, S_FETCH, S_DECODE, S_OPB1, S_OPB2,
      S_MEMRD, S_BRREL, S_PUSH, S_PULL, S_PULLC
   } state_t;
endpackage

// *** sim/mem_model.sv ***
// behavioural program and data memory on the cpu bus
`timescale 1ns/1ps
module mem_model
   import cpu_core_pkg::*;
(
   // bus from the core
   input  wire logic          mclk_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic          rd_i,
   input  wire logic          wr_i,
   input  wire logic [7:0]    wdata_i,
   // read data back
   output logic [7:0]         rdata_o
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [7:0] last_reg;
   // zero wait states; released bus shows inverse so stale data never passes
   assign rdata_o = rd_i ? mem[addr_i] : ~last_reg;
   // writes land at the strobe edge; plain always so the bench may preload the array
   always @(posedge mclk_i)
   begin
      if (wr_i) mem[addr_i] <= wdata_i;
      if (rd_i) last_reg <= mem[addr_i];
   end
endmodule

// *** sim/testbench.sv ***
// self-checking bench: stacking, rmw, bit ops and interrupt sequencing
`timescale 1ns/1ps
module testbench
   import cpu_core_pkg::*;
;
   logic mclk_i, rst_i, mem_rd_o, mem_wr_o, ext_irq_n_i, timer_zero_i;
   logic irq_mask_o, tmr_flag_o, tmr_mask_o;
   logic [AW-1:0] mem_addr_o;
   logic [7:0] mem_wdata_o, mem_rdata_i;
   logic [1:0] int_mode_i;
   int fail_count = 0, checks = 0;
   logic [15:0] wlog [$];
   logic [AW-1:0] vlog [$];
   // expected bus writes: {address low byte, data}
   logic [15:0] rows [20] = '{16'h7f06, 16'h7e01, 16'h7d33, 16'h7c55, 16'h7be0,
      16'h4055, 16'h4056, 16'h4057, 16'h0980, 16'h7f10, 16'h7e01, 16'h7d33,
      16'h7c80, 16'h7be4, 16'h0900, 16'h7f10, 16'h7e01, 16'h7d33, 16'h7c80, 16'h7be4};
   logic [AW-1:0] vrows [4] = '{VEC_RESET, VEC_TRAP, VEC_TIMER, VEC_EXT};
   cpu_core dut (.mclk_i(mclk_i), .rst_i(rst_i), .mem_addr_o(mem_addr_o),
      .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i), .ext_irq_n_i(ext_irq_n_i), .int_mode_i(int_mode_i),
      .timer_zero_i(timer_zero_i), .irq_mask_o(irq_mask_o), .tmr_flag_o(tmr_flag_o),
      .tmr_mask_o(tmr_mask_o));
   mem_model u_mem (.mclk_i(mclk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
      .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   // free-running cpu clock
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   // log every write and every vector high-byte fetch
   always @(posedge mclk_i)
   begin
      if (mem_wr_o) wlog.push_back({mem_addr_o[7:0], mem_wdata_o});
      if (mem_rd_o && mem_addr_o[12:3] == 10'h3ff && !mem_addr_o[0]) vlog.push_back(mem_addr_o);
   end
   task automatic stop_test();
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic put(input logic [AW-1:0] a, input logic [7:0] b[]);
      foreach (b[i]) u_mem.mem[a + AW'(i)] = b[i];
   endtask
   // bounded wait for a number of logged writes
   task automatic wait_w(input int n);
      for (int i = 0; i < 400 && wlog.size() < n; i++) @(posedge mclk_i);
      if (wlog.size() < n)
      begin
         fail_count++;
         $display("[ERR] %0t timeout waiting for bus writes", $time);
         stop_test();
      end
   endtask
   // main sequence: vectors, program, handlers, then checks
   initial
   begin
      rst_i = 1'b1;
      ext_irq_n_i = 1'b1;
      int_mode_i = 2'h2;
      timer_zero_i = 1'b0;
      put(13'h1ff8, '{8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00});
      put(13'h0100, '{8'hA6, 8'h55, 8'hAE, 8'h33, 8'h9A, 8'h83, 8'hB7, 8'h40, 8'h3C,
         8'h40, 8'h10, 8'h40, 8'hA6, 8'h80, 8'hB7, 8'h09, 8'h20, 8'hFE});
      put(13'h0200, '{8'h80});
      put(13'h0300, '{8'h4F, 8'hB7, 8'h09, 8'h80});
      put(13'h0400, '{8'h20, 8'hFE});
      repeat (10) @(posedge mclk_i);
      chk_b(irq_mask_o, 1'b1);
      chk_b(tmr_mask_o, 1'b1);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      timer_zero_i <= 1'b1;
      @(posedge mclk_i);
      timer_zero_i <= 1'b0;
      wait_w(5);
      repeat (3) @(posedge mclk_i);
      chk_b(irq_mask_o, 1'b1);
      chk_b(tmr_flag_o, 1'b1);
      wait_w(15);
      repeat (2) @(posedge mclk_i);
      chk_b(tmr_flag_o, 1'b0);
      repeat (30) @(posedge mclk_i);
      ext_irq_n_i <= 1'b0;
      wait_w(20);
      repeat (3) @(posedge mclk_i);
      chk_b(irq_mask_o, 1'b1);
      chk_v(16'(wlog.size()), 16'd20);
      for (int i = 0; i < 20; i++) chk_v(wlog[i], rows[i]);
      chk_v(16'(vlog.size()), 16'h0004);
      for (int i = 0; i < 4; i++) chk_v({3'h0, vlog[i]}, {3'h0, vrows[i]});
      stop_test();
   end
endmodule
